// >>> crccfg_engine.sv
// CRC shift engine: two data bits per clock through a programmable polynomial
module crccfg_engine
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [31:0] word_in,
    input wire logic [4:0] width_sel,
    input wire logic [4:0] length_sel,
    input wire logic [31:0] taps,
    input wire logic clear_result,
    output logic busy,
    output logic [31:0] result
);
    logic [31:0] data_reg;
    logic [5:0] left_reg;
    logic [31:0] poly;

    ////////////////////////////////////////////////////////////////////////
    // X0 is forced on; X(N) is implied by the feedback point, so never stored
    always_comb
    begin
        poly = taps;
        poly[0] = 1'b1;
    end

    function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic din,
                                             input logic [4:0] len, input logic [31:0] p);
        logic fb;
        logic [31:0] nxt;
        fb = crc[len] ^ din;
        nxt = {crc[30:0], 1'b0} & ((32'h0000_0002 << len) - 32'h0000_0001);
        crc_step = fb ? (nxt ^ p) : nxt;
    endfunction : crc_step

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_reg <= 32'h0000_0000;
            left_reg <= 6'h00;
            result <= 32'h0000_0000;
        end
        else if (clear_result)
        begin
            result <= 32'h0000_0000;
            left_reg <= 6'h00;
        end
        else if (load)
        begin
            // Left-align the word so the MSb of the configured width leads
            data_reg <= word_in << (5'h1F - width_sel);
            left_reg <= {1'b0, width_sel} + 6'h01;
        end
        else if (left_reg > 6'h01)
        begin
            result <= crc_step(crc_step(result, data_reg[31], length_sel, poly),
                               data_reg[30], length_sel, poly);
            data_reg <= {data_reg[29:0], 2'h0};
            left_reg <= left_reg - 6'h02;
        end
        else if (left_reg == 6'h01)
        begin
            // Odd width: the last single bit
            result <= crc_step(result, data_reg[31], length_sel, poly);
            left_reg <= 6'h00;
        end
    end

    assign busy = (left_reg != 6'h00);
endmodule : crccfg_engine

// >>> crccfg_pkg.sv
// Constants for the CRC width, length and polynomial configuration block
package crccfg_pkg;
    localparam logic [7:0] CRCCFG_OFF_WIDTH_LENGTH = 8'h00;
    localparam logic [7:0] CRCCFG_OFF_POLY_LOW = 8'h04;
    localparam logic [7:0] CRCCFG_OFF_POLY_HIGH = 8'h08;
    localparam logic [7:0] CRCCFG_OFF_STATUS = 8'h0C;
    localparam logic [7:0] CRCCFG_OFF_DATA = 8'h10;
    localparam logic [7:0] CRCCFG_OFF_RESULT = 8'h14;
    localparam int CRCCFG_WIDTH_LSB = 8;
    localparam int CRCCFG_LENGTH_LSB = 0;
    localparam logic [15:0] CRCCFG_WL_MASK = 16'h1F1F;
    localparam logic [15:0] CRCCFG_LOW_MASK = 16'hFFFE;
    localparam logic [15:0] CRCCFG_CFG_RESET = 16'h0000;
    localparam logic [4:0] CRCCFG_DEPTH_SMALL = 5'h04;
    localparam logic [4:0] CRCCFG_DEPTH_MID = 5'h08;
    localparam logic [4:0] CRCCFG_DEPTH_LARGE = 5'h10;
    localparam logic [4:0] CRCCFG_WIDE_MIN = 5'h10;
    localparam logic [4:0] CRCCFG_MID_MIN = 5'h08;
    localparam int CRCCFG_BITS_PER_CYCLE = 2;
    // Status bit positions
    localparam int CRCCFG_ST_GO = 0;
    localparam int CRCCFG_ST_EMPTY = 1;
    localparam int CRCCFG_ST_FULL = 2;
    localparam int CRCCFG_ST_COUNT_LSB = 8;
    localparam int CRCCFG_ST_EN = 15;
    localparam logic [1:0] CRCCFG_HTRANS_NONSEQ = 2'h2;
endpackage : crccfg_pkg

// >>> crccfg_tb_top.sv
// Self-checking testbench for the CRC configuration block
module crccfg_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] all_m = 32'hFFFFFFFF;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    int num_errors = 0;
    int comparisons = 0;
    assign hready = hreadyout;
    always #5 clock = ~clock;
    crccfg_top i_crccfg_top (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
    ////////////////////////////////////////////////////////////////////////////////
    // Entered just after a rising edge, returns on the edge that ends the data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= crccfg_pkg::CRCCFG_HTRANS_NONSEQ;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        htrans <= 2'h0;
        hsel <= 1'b0;
        if (w) hwdata <= d;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        comparisons++;
        if ((q & m) !== e)
        begin
            $display("ERROR reg %h expected %h seen %h", a, e, q & m);
            num_errors++;
        end
    endtask : rd
    // Bit-serial reference: w data bits MSb first through an n-bit register
    function automatic logic [31:0] crc_ref(input logic [31:0] d, input logic [31:0] p,
        input int n, input int w);
        logic [31:0] c;
        c = 32'h0;
        for (int i = w - 1; i >= 0; i--)
            c = ((c << 1) ^ ((c[n - 1] ^ d[i]) ? (p | 32'h1) : 32'h0)) & ((32'h1 << n) - 1);
        return c;
    endfunction : crc_ref
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_config;
        logic [31:0] pat [4] = '{32'hFFFFFFFF, 32'h00000000, 32'hA5A50A15, 32'h5A5A1501};
        rd(8'h00, 32'h0, all_m);
        rd(8'h04, 32'h0, all_m);
        rd(8'h08, 32'h0, all_m);
        foreach (pat[i])
        begin
            wr(8'h00, pat[i]);
            rd(8'h00, pat[i] & 32'h1F1F, all_m);
            wr(8'h04, pat[i]);
            rd(8'h04, pat[i] & 32'hFFFE, all_m);
            wr(8'h08, pat[i]);
            rd(8'h08, pat[i] & 32'hFFFF, all_m);
        end
    endtask : t_config
    // One word beyond the depth is pushed and must be refused
    task automatic t_depth;
        logic [4:0] ws [6] = '{5'h1F, 5'h10, 5'h0F, 5'h08, 5'h07, 5'h00};
        int dp [6] = '{4, 4, 8, 8, 16, 16};
        foreach (ws[i])
        begin
            wr(8'h0C, 32'h0);
            wr(8'h00, {19'h0, ws[i], 8'h0F});
            wr(8'h0C, 32'h8000);
            repeat (dp[i] + 1) wr(8'h10, 32'h1);
            rd(8'h0C, 32'h8004 | (dp[i] << 8), all_m);
        end
    endtask : t_depth
    task automatic t_engine;
        wr(8'h0C, 32'h0);
        wr(8'h00, 32'h1F0F);
        wr(8'h04, 32'h1021);
        wr(8'h08, 32'h0);
        wr(8'h0C, 32'h8000);
        wr(8'h10, 32'h12345678);
        wr(8'h14, 32'h0);
        wr(8'h0C, 32'h8001);
        rd(8'h0C, 32'h1, 32'h1);
        repeat (8) @(posedge clock);
        rd(8'h0C, 32'h1, 32'h1);
        repeat (20) @(posedge clock);
        rd(8'h0C, 32'h8002, all_m);
        rd(8'h14, crc_ref(32'h12345678, 32'h1020, 16, 32), 32'hFFFF);
        // Odd 7-bit word through a full 32-bit polynomial using the high taps
        wr(8'h0C, 32'h0);
        wr(8'h00, 32'h061F);
        wr(8'h04, 32'h1DB7);
        wr(8'h08, 32'h04C1);
        wr(8'h0C, 32'h8000);
        wr(8'h10, 32'hFFFFFFD5);
        wr(8'h14, 32'h0);
        wr(8'h0C, 32'h8001);
        repeat (10) @(posedge clock);
        rd(8'h0C, 32'h8002, all_m);
        rd(8'h14, crc_ref(32'hD5, 32'h04C11DB6, 32, 7), all_m);
    endtask : t_engine
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    initial
    begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_config();
        t_depth();
        t_engine();
        end_sim();
    end
    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clock);
        num_errors++;
        end_sim();
    end
endmodule : crccfg_tb_top
bind crccfg_top crccfg_top_asserts i_crccfg_top_asserts (.clock(clock), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// >>> crccfg_top.sv
// CRC configuration registers on AHB-Lite, input FIFO and engine control
module crccfg_top
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    logic rst_meta_reg;
    logic rst_n_reg;
    logic [15:0] wl_reg;
    logic [15:0] poly_low_reg;
    logic [15:0] poly_high_reg;
    logic enable_reg;
    logic go_reg;
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [7:0] addr_reg;
    logic [31:0] fifo_mem [16];
    logic [3:0] wr_ptr_reg;
    logic [3:0] rd_ptr_reg;
    logic [4:0] count_reg;
    logic [4:0] depth;
    logic [4:0] width_sel;
    logic [4:0] length_sel;
    logic push;
    logic pop;
    logic busy;
    logic clear_result;
    logic [31:0] result;
    logic [31:0] status;
    logic [15:0] wl_view;
    logic [15:0] low_view;
    logic [15:0] high_view;

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite address phase capture; always zero wait states, OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge clock or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend_reg <= hsel && htrans[1] && hwrite;
            rd_pend_reg <= hsel && htrans[1] && !hwrite;
            addr_reg <= haddr;
        end
    end

    assign width_sel = wl_reg[crccfg_pkg::CRCCFG_WIDTH_LSB +: 5];
    assign length_sel = wl_reg[crccfg_pkg::CRCCFG_LENGTH_LSB +: 5];

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge clock or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            wl_reg <= crccfg_pkg::CRCCFG_CFG_RESET;
            poly_low_reg <= crccfg_pkg::CRCCFG_CFG_RESET;
            poly_high_reg <= crccfg_pkg::CRCCFG_CFG_RESET;
        end
        else if (wr_pend_reg)
        begin
            if (addr_reg == crccfg_pkg::CRCCFG_OFF_WIDTH_LENGTH)
                wl_reg <= hwdata[15:0] & crccfg_pkg::CRCCFG_WL_MASK;
            if (addr_reg == crccfg_pkg::CRCCFG_OFF_POLY_LOW)
                poly_low_reg <= hwdata[15:0] & crccfg_pkg::CRCCFG_LOW_MASK;
            if (addr_reg == crccfg_pkg::CRCCFG_OFF_POLY_HIGH)
                poly_high_reg <= hwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable and go; go self-clears once the FIFO and engine drain
    always_ff @(posedge clock or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            enable_reg <= 1'b0;
            go_reg <= 1'b0;
        end
        else if (wr_pend_reg && addr_reg == crccfg_pkg::CRCCFG_OFF_STATUS)
        begin
            enable_reg <= hwdata[crccfg_pkg::CRCCFG_ST_EN];
            go_reg <= hwdata[crccfg_pkg::CRCCFG_ST_GO];
        end
        else if (go_reg && count_reg == 5'h00 && !busy && !push)
            go_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Input FIFO; depth shrinks as the word widens
    always_comb
    begin
        if (width_sel >= crccfg_pkg::CRCCFG_WIDE_MIN)
            depth = crccfg_pkg::CRCCFG_DEPTH_SMALL;
        else if (width_sel >= crccfg_pkg::CRCCFG_MID_MIN)
            depth = crccfg_pkg::CRCCFG_DEPTH_MID;
        else
            depth = crccfg_pkg::CRCCFG_DEPTH_LARGE;
    end

    // Writes to a full FIFO are dropped
    assign push = wr_pend_reg && addr_reg == crccfg_pkg::CRCCFG_OFF_DATA && enable_reg
                  && count_reg < depth;
    // A result clear resets the engine, so a pop then would lose its word
    assign pop = go_reg && enable_reg && !busy && !clear_result && count_reg != 5'h00;
    assign clear_result = wr_pend_reg && addr_reg == crccfg_pkg::CRCCFG_OFF_RESULT;

    always_ff @(posedge clock)
    begin
        if (push)
            fifo_mem[wr_ptr_reg] <= hwdata;
    end

    always_ff @(posedge clock or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            wr_ptr_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
            count_reg <= 5'h00;
        end
        else if (!enable_reg)
        begin
            // Disabling empties the FIFO
            wr_ptr_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
            count_reg <= 5'h00;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 4'h1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 4'h1;
            if (push && !pop)
                count_reg <= count_reg + 5'h01;
            else if (pop && !push)
                count_reg <= count_reg - 5'h01;
        end
    end

    crccfg_engine u_engine
    (
        .clock(clock),
        .rst_n(rst_n_reg),
        .load(pop),
        .word_in(fifo_mem[rd_ptr_reg]),
        .width_sel(width_sel),
        .length_sel(length_sel),
        .taps({poly_high_reg, poly_low_reg}),
        .clear_result(clear_result),
        .busy(busy),
        .result(result)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read data
    // A config register write lands in its data phase; a pipelined read in that same cycle must see it
    always_comb
    begin
        wl_view = wl_reg;
        low_view = poly_low_reg;
        high_view = poly_high_reg;
        if (wr_pend_reg && addr_reg == crccfg_pkg::CRCCFG_OFF_WIDTH_LENGTH)
            wl_view = hwdata[15:0] & crccfg_pkg::CRCCFG_WL_MASK;
        if (wr_pend_reg && addr_reg == crccfg_pkg::CRCCFG_OFF_POLY_LOW)
            low_view = hwdata[15:0] & crccfg_pkg::CRCCFG_LOW_MASK;
        if (wr_pend_reg && addr_reg == crccfg_pkg::CRCCFG_OFF_POLY_HIGH)
            high_view = hwdata[15:0];
    end

    always_comb
    begin
        status = 32'h0000_0000;
        status[crccfg_pkg::CRCCFG_ST_GO] = go_reg;
        status[crccfg_pkg::CRCCFG_ST_EMPTY] = (count_reg == 5'h00);
        status[crccfg_pkg::CRCCFG_ST_FULL] = (count_reg == depth);
        status[crccfg_pkg::CRCCFG_ST_COUNT_LSB +: 5] = count_reg;
        status[crccfg_pkg::CRCCFG_ST_EN] = enable_reg;
    end

    always_ff @(posedge clock or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            hrdata <= 32'h0000_0000;
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            unique case (haddr)
                crccfg_pkg::CRCCFG_OFF_WIDTH_LENGTH: hrdata <= {16'h0000, wl_view};
                crccfg_pkg::CRCCFG_OFF_POLY_LOW: hrdata <= {16'h0000, low_view};
                crccfg_pkg::CRCCFG_OFF_POLY_HIGH: hrdata <= {16'h0000, high_view};
                crccfg_pkg::CRCCFG_OFF_STATUS: hrdata <= status;
                crccfg_pkg::CRCCFG_OFF_RESULT: hrdata <= result;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule : crccfg_top

// >>> crccfg_top_asserts.sv
// Bus and register checker for the CRC configuration block
module crccfg_top_asserts
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp
);
    logic tk;
    assign tk = hsel & hready & htrans[1];
    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////////
    chk_ready_high: assert property (hreadyout)
        else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    chk_low_bit0: assert property ((tk && !hwrite && haddr == 8'h04) |=> !hrdata[0])
        else $error("low tap bit 0 reads set");
    chk_low_upper: assert property ((tk && !hwrite && haddr == 8'h04) |=>
        hrdata[31:16] == 16'h0)
        else $error("low tap upper half set");
    chk_high_upper: assert property ((tk && !hwrite && haddr == 8'h08) |=>
        hrdata[31:16] == 16'h0)
        else $error("high tap upper half set");
    // Read two cycles after the write so the write data phase has landed
    chk_wl_readback: assert property ((tk && hwrite && haddr == 8'h00) ##2
        (tk && !hwrite && haddr == 8'h00) |=> hrdata == ($past(hwdata, 2) & 32'h1F1F))
        else $error("width length readback wrong");
    chk_low_readback: assert property ((tk && hwrite && haddr == 8'h04) ##2
        (tk && !hwrite && haddr == 8'h04) |=> hrdata == ($past(hwdata, 2) & 32'hFFFE))
        else $error("low taps readback wrong");
    chk_high_readback: assert property ((tk && hwrite && haddr == 8'h08) ##2
        (tk && !hwrite && haddr == 8'h08) |=> hrdata == ($past(hwdata, 2) & 32'hFFFF))
        else $error("high taps readback wrong");
endmodule : crccfg_top_asserts
